// ===== pkg/rs485_dir_cfg.svh
// offsets, field positions, reset values and timing counts for the direction controller
`ifndef RS485_DIR_CFG_SVH
`define RS485_DIR_CFG_SVH
`define RDC_OFF_CTRL     8'h00
`define RDC_OFF_TXDATA   8'h04
`define RDC_OFF_ADDR     8'h08
`define RDC_OFF_STATUS   8'h0C
`define RDC_OFF_RXDATA   8'h10
`define RDC_OFF_IRQSTAT  8'h14
`define RDC_OFF_IRQCLR   8'h18
`define RDC_OFF_IRQEN    8'h1C
`define RDC_OFF_BAUD     8'h20
// control fields
`define RDC_CTRL_AUTO    0
`define RDC_CTRL_RTS     1
`define RDC_CTRL_ECHO    2
`define RDC_CTRL_FOUR    3
`define RDC_CTRL_LOOP    4
`define RDC_CTRL_ACK     5
`define RDC_CTRL_RST     6'h01
// interrupt fields
`define RDC_IRQ_TXDONE   0
`define RDC_IRQ_RXRDY    1
`define RDC_IRQ_CONTEND  2
`define RDC_IRQ_OVERRUN  3
`define RDC_IRQ_NOACK    4
// txdata bit that opens a command with the slave address
`define RDC_TX_CMD       8
`define RDC_BAUD_RST     16'h0364
`define RDC_ACK_CYCLES   200000
`define RDC_TURN_CYCLES  2000
`endif

// ===== pkg/rs485_dir_pkg.sv
// types shared by both ends of the shared-pair link
package rs485_dir_pkg;
   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} ser_state_e;
   typedef enum logic [1:0] {NODE_ADDR, NODE_DATA, NODE_TURN, NODE_SEND} node_state_e;
   typedef logic [7:0] char_t;
endpackage

// ===== pkg/rs485_link_if.sv
// shared differential pair between the controller and a remote node
`timescale 1ns/100ps
`default_nettype none
interface rs485_link_if;
   logic devTxd;
   logic devDe;
   logic devRe;
   logic fourWire;
   logic nodeTxd;
   logic nodeDe;
   logic pairLine;
   logic devRxLine;
   logic nodeRxLine;
   // biased idle is mark; two drivers at once resolve towards space
   assign pairLine   = (devDe ? devTxd : 1'b1) & (nodeDe ? nodeTxd : 1'b1);
   assign devRxLine  = fourWire ? (nodeDe ? nodeTxd : 1'b1) : pairLine;
   assign nodeRxLine = fourWire ? (devDe ? devTxd : 1'b1) : pairLine;
   modport device (output devTxd, output devDe, output devRe, output fourWire,
                   input devRxLine);
   modport node (output nodeTxd, output nodeDe, input nodeRxLine);
endinterface
`default_nettype wire

// ===== design/rs485_node.sv
// remote addressed node: listens for address and data, replies after its turnaround delay
`include "rs485_dir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rs485_node #(
   parameter logic [15:0] BAUD_DIV   = `RDC_BAUD_RST,
   parameter int          TURN_CYCLES = `RDC_TURN_CYCLES
) (
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire logic [7:0] myAddr,
   input  wire logic [7:0] replyData,
   output logic [7:0]     cmdData,
   output logic           cmdStrobe,
   output logic           replyBusy,
   rs485_link_if.node     lnk
);
   rs485_dir_pkg::node_state_e nState_reg;
   rs485_dir_pkg::ser_state_e  rxState_reg;
   rs485_dir_pkg::ser_state_e  txState_reg;
   logic [15:0] rxCnt_reg;
   logic [15:0] txCnt_reg;
   logic [2:0]  rxBit_reg;
   logic [2:0]  txBit_reg;
   logic [7:0]  rxShift_reg;
   logic [7:0]  txShift_reg;
   logic [31:0] turnCnt_reg;
   logic        rxDone;
   logic        txEnd;
   logic        txStart;

   // ----------------------------------------
   // receiver, off while this node drives
   // ----------------------------------------
   assign rxDone = rxState_reg == rs485_dir_pkg::SER_STOP && rxCnt_reg == BAUD_DIV - 16'h0001
                   && lnk.nodeRxLine;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxState_reg <= rs485_dir_pkg::SER_IDLE;
         rxCnt_reg   <= 16'h0000;
         rxBit_reg   <= 3'h0;
         rxShift_reg <= 8'h00;
      end else if (lnk.nodeDe) begin
         rxState_reg <= rs485_dir_pkg::SER_IDLE;
      end else begin
         rxCnt_reg <= rxCnt_reg + 16'h0001;
         case (rxState_reg)
            rs485_dir_pkg::SER_IDLE: begin
               rxCnt_reg <= 16'h0000;
               if (!lnk.nodeRxLine) rxState_reg <= rs485_dir_pkg::SER_START;
            end
            rs485_dir_pkg::SER_START: if (rxCnt_reg == (BAUD_DIV >> 1)) begin
               rxCnt_reg   <= 16'h0000;
               rxBit_reg   <= 3'h0;
               rxState_reg <= lnk.nodeRxLine ? rs485_dir_pkg::SER_IDLE : rs485_dir_pkg::SER_DATA;
            end
            rs485_dir_pkg::SER_DATA: if (rxCnt_reg == BAUD_DIV - 16'h0001) begin
               rxCnt_reg   <= 16'h0000;
               rxShift_reg <= {lnk.nodeRxLine, rxShift_reg[7:1]};
               rxBit_reg   <= rxBit_reg + 3'h1;
               if (rxBit_reg == 3'h7) rxState_reg <= rs485_dir_pkg::SER_STOP;
            end
            rs485_dir_pkg::SER_STOP: if (rxCnt_reg == BAUD_DIV - 16'h0001)
               rxState_reg <= rs485_dir_pkg::SER_IDLE;
            default: rxState_reg <= rs485_dir_pkg::SER_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // command sequencing: answer only when addressed
   // ----------------------------------------
   assign txStart = nState_reg == rs485_dir_pkg::NODE_TURN && turnCnt_reg == TURN_CYCLES - 1;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nState_reg  <= rs485_dir_pkg::NODE_ADDR;
         turnCnt_reg <= 32'h0000_0000;
         cmdData     <= 8'h00;
         cmdStrobe   <= 1'b0;
      end else begin
         cmdStrobe <= 1'b0;
         case (nState_reg)
            rs485_dir_pkg::NODE_ADDR: if (rxDone && rxShift_reg == myAddr)
               nState_reg <= rs485_dir_pkg::NODE_DATA;
            rs485_dir_pkg::NODE_DATA: if (rxDone) begin
               cmdData     <= rxShift_reg;
               cmdStrobe   <= 1'b1;
               turnCnt_reg <= 32'h0000_0000;
               nState_reg  <= rs485_dir_pkg::NODE_TURN;
            end
            rs485_dir_pkg::NODE_TURN: begin
               turnCnt_reg <= turnCnt_reg + 32'h0000_0001;
               if (txStart) nState_reg <= rs485_dir_pkg::NODE_SEND;
            end
            rs485_dir_pkg::NODE_SEND: if (txEnd) nState_reg <= rs485_dir_pkg::NODE_ADDR;
            default: nState_reg <= rs485_dir_pkg::NODE_ADDR;
         endcase
      end
   end

   // ----------------------------------------
   // reply transmitter
   // ----------------------------------------
   assign txEnd = txState_reg == rs485_dir_pkg::SER_STOP && txCnt_reg == BAUD_DIV - 16'h0001;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txState_reg <= rs485_dir_pkg::SER_IDLE;
         txCnt_reg   <= 16'h0000;
         txBit_reg   <= 3'h0;
         txShift_reg <= 8'hFF;
      end else begin
         txCnt_reg <= txCnt_reg + 16'h0001;
         case (txState_reg)
            rs485_dir_pkg::SER_IDLE: begin
               txCnt_reg <= 16'h0000;
               if (txStart) begin
                  txShift_reg <= replyData;
                  txState_reg <= rs485_dir_pkg::SER_START;
               end
            end
            rs485_dir_pkg::SER_START: if (txCnt_reg == BAUD_DIV - 16'h0001) begin
               txCnt_reg   <= 16'h0000;
               txBit_reg   <= 3'h0;
               txState_reg <= rs485_dir_pkg::SER_DATA;
            end
            rs485_dir_pkg::SER_DATA: if (txCnt_reg == BAUD_DIV - 16'h0001) begin
               txCnt_reg   <= 16'h0000;
               txShift_reg <= {1'b1, txShift_reg[7:1]};
               txBit_reg   <= txBit_reg + 3'h1;
               if (txBit_reg == 3'h7) txState_reg <= rs485_dir_pkg::SER_STOP;
            end
            rs485_dir_pkg::SER_STOP: if (txEnd) txState_reg <= rs485_dir_pkg::SER_IDLE;
            default: txState_reg <= rs485_dir_pkg::SER_IDLE;
         endcase
      end
   end

   assign lnk.nodeDe  = txState_reg != rs485_dir_pkg::SER_IDLE;
   assign lnk.nodeTxd = txState_reg == rs485_dir_pkg::SER_DATA ? txShift_reg[0]
                        : txState_reg != rs485_dir_pkg::SER_START;
   assign replyBusy   = nState_reg == rs485_dir_pkg::NODE_TURN || lnk.nodeDe;
endmodule // rs485_node
`default_nettype wire

// ===== design/rs485_dir_ctrl.sv
// controller end: apb registers, serial engine and line driver/receiver direction control
//
// Chosen here: the placing of the registers and register access over APB.
`include "rs485_dir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
// Function
// - rts mode: rts raised before sending
// - only one driver enabled at once
// - auto mode enables driver from outgoing data
// - receiver off during own transmit
// - loopback compare flags contention
// - slaves answer only master requests
// - command begins with slave address
// - four-wire master: driver, receiver always on
// - master never requests several slaves together
// - two-wire: driver tristated when idle
// - master releases before slave turnaround
// - detect contention, expect ack, resend (no resend here: a missing ack only raises the no-ack interrupt)
// - unused handshake outputs held high
module rs485_dir_ctrl #(
   parameter int ACK_CYCLES = `RDC_ACK_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             hsRts,
   output logic             hsDtr,
   rs485_link_if.device     lnk
);
   logic [5:0]  ctrl_reg;
   logic [15:0] baud_reg;
   logic [7:0]  addr_reg;
   logic [4:0]  irqStat_reg;
   logic [4:0]  irqStat_next;
   logic [4:0]  irqEn_reg;
   logic [4:0]  irqSet;
   logic [7:0]  rxData_reg;
   logic        rxValid_reg;
   logic [7:0]  txHold_reg;
   logic        txHoldValid_reg;
   logic        addrPend_reg;
   logic        cmdOpen_reg;
   logic        ackWait_reg;
   logic [31:0] ackCnt_reg;
   rs485_dir_pkg::ser_state_e txState_reg;
   rs485_dir_pkg::ser_state_e rxState_reg;
   logic [15:0] txCnt_reg;
   logic [15:0] rxCnt_reg;
   logic [2:0]  txBit_reg;
   logic [2:0]  rxBit_reg;
   logic [7:0]  txShift_reg;
   logic [7:0]  txSent_reg;
   logic [7:0]  rxShift_reg;
   logic        wrAcc;
   logic        rdAcc;
   logic        mapped;
   logic        txActive;
   logic        txMayStart;
   logic        txEnd;
   logic        rxEnable;
   logic        rxDone;
   logic        ownEcho;

   function automatic logic bitEnd(input logic [15:0] cnt, input logic [15:0] div);
      return cnt == div - 16'h0001;
   endfunction

   function automatic logic isReg(input logic [7:0] a);
      return a == `RDC_OFF_CTRL || a == `RDC_OFF_TXDATA || a == `RDC_OFF_ADDR
          || a == `RDC_OFF_STATUS || a == `RDC_OFF_RXDATA || a == `RDC_OFF_IRQSTAT
          || a == `RDC_OFF_IRQCLR || a == `RDC_OFF_IRQEN || a == `RDC_OFF_BAUD;
   endfunction

   // ----------------------------------------
   // apb slave, zero wait states
   // ----------------------------------------
   assign mapped  = isReg(paddr);
   assign wrAcc   = psel && penable && pwrite && mapped;
   assign rdAcc   = psel && penable && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            `RDC_OFF_CTRL:    prdata <= {26'h0, ctrl_reg};
            `RDC_OFF_ADDR:    prdata <= {24'h0, addr_reg};
            `RDC_OFF_STATUS:  prdata <= {27'h0, ackWait_reg, txHoldValid_reg, rxValid_reg,
                                         lnk.devDe, txActive};
            `RDC_OFF_RXDATA:  prdata <= {23'h0, rxValid_reg, rxData_reg};
            `RDC_OFF_IRQSTAT: prdata <= {27'h0, irqStat_reg};
            `RDC_OFF_IRQEN:   prdata <= {27'h0, irqEn_reg};
            `RDC_OFF_BAUD:    prdata <= {16'h0, baud_reg};
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= `RDC_CTRL_RST;
         baud_reg  <= `RDC_BAUD_RST;
         addr_reg  <= 8'h00;
         irqEn_reg <= 5'h00;
      end else if (wrAcc) begin
         case (paddr)
            `RDC_OFF_CTRL:  ctrl_reg  <= pwdata[5:0];
            `RDC_OFF_ADDR:  addr_reg  <= pwdata[7:0];
            `RDC_OFF_IRQEN: irqEn_reg <= pwdata[4:0];
            `RDC_OFF_BAUD:  baud_reg  <= (pwdata[15:0] < 16'h0004) ? 16'h0004 : pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // transmit holding and command framing
   // ----------------------------------------
   // rts mode waits for software rts
   assign txMayStart = ctrl_reg[`RDC_CTRL_AUTO] || ctrl_reg[`RDC_CTRL_FOUR]
                       || ctrl_reg[`RDC_CTRL_RTS];
   assign txEnd = txState_reg == rs485_dir_pkg::SER_STOP && bitEnd(txCnt_reg, baud_reg);
   assign txActive = txState_reg != rs485_dir_pkg::SER_IDLE;

   // a write while the holding slot is full is dropped; software polls status bit 3
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txHold_reg      <= 8'h00;
         txHoldValid_reg <= 1'b0;
         addrPend_reg    <= 1'b0;
      end else if (wrAcc && paddr == `RDC_OFF_TXDATA && !txHoldValid_reg) begin
         txHold_reg      <= pwdata[7:0];
         txHoldValid_reg <= 1'b1;
         // one slave address leads the command
         addrPend_reg    <= pwdata[`RDC_TX_CMD];
      end else if (txMayStart && (!txActive || txEnd) && txHoldValid_reg) begin
         if (addrPend_reg) addrPend_reg <= 1'b0;
         else txHoldValid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // transmit shifter
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txState_reg <= rs485_dir_pkg::SER_IDLE;
         txCnt_reg   <= 16'h0000;
         txBit_reg   <= 3'h0;
         txShift_reg <= 8'hFF;
         txSent_reg  <= 8'h00;
      end else begin
         txCnt_reg <= txCnt_reg + 16'h0001;
         case (txState_reg)
            rs485_dir_pkg::SER_IDLE, rs485_dir_pkg::SER_STOP: begin
               if (txState_reg == rs485_dir_pkg::SER_IDLE || txEnd) begin
                  txCnt_reg   <= 16'h0000;
                  txState_reg <= rs485_dir_pkg::SER_IDLE;
                  // back to back: next start bit follows the stop bit directly
                  if (txMayStart && txHoldValid_reg) begin
                     txShift_reg <= addrPend_reg ? addr_reg : txHold_reg;
                     txSent_reg  <= addrPend_reg ? addr_reg : txHold_reg;
                     txState_reg <= rs485_dir_pkg::SER_START;
                  end
               end
            end
            rs485_dir_pkg::SER_START: if (bitEnd(txCnt_reg, baud_reg)) begin
               txCnt_reg   <= 16'h0000;
               txBit_reg   <= 3'h0;
               txState_reg <= rs485_dir_pkg::SER_DATA;
            end
            rs485_dir_pkg::SER_DATA: if (bitEnd(txCnt_reg, baud_reg)) begin
               txCnt_reg   <= 16'h0000;
               txShift_reg <= {1'b1, txShift_reg[7:1]};
               txBit_reg   <= txBit_reg + 3'h1;
               if (txBit_reg == 3'h7) txState_reg <= rs485_dir_pkg::SER_STOP;
            end
            default: txState_reg <= rs485_dir_pkg::SER_IDLE;
         endcase
      end
   end

   assign lnk.devTxd = txState_reg == rs485_dir_pkg::SER_DATA ? txShift_reg[0]
                       : txState_reg != rs485_dir_pkg::SER_START;
   assign lnk.fourWire = ctrl_reg[`RDC_CTRL_FOUR];

   // ----------------------------------------
   // direction control
   // ----------------------------------------
   // four-wire keeps both on; auto follows shifter through stop
   // drops the same cycle the stop bit ends; else rts
   assign lnk.devDe = ctrl_reg[`RDC_CTRL_FOUR] ? 1'b1
                      : ctrl_reg[`RDC_CTRL_AUTO] ? txActive : ctrl_reg[`RDC_CTRL_RTS];
   assign rxEnable  = ctrl_reg[`RDC_CTRL_FOUR] || !(ctrl_reg[`RDC_CTRL_ECHO] && lnk.devDe);
   assign lnk.devRe = rxEnable;
   assign hsRts = (ctrl_reg[`RDC_CTRL_AUTO] || ctrl_reg[`RDC_CTRL_FOUR]) ? 1'b1
                  : ctrl_reg[`RDC_CTRL_RTS];
   assign hsDtr = 1'b1;

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   assign rxDone = rxState_reg == rs485_dir_pkg::SER_STOP && bitEnd(rxCnt_reg, baud_reg)
                   && lnk.devRxLine;
   // stop-bit sample lands inside our own stop bit when looped back
   assign ownEcho = !ctrl_reg[`RDC_CTRL_FOUR] && txActive;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxState_reg <= rs485_dir_pkg::SER_IDLE;
         rxCnt_reg   <= 16'h0000;
         rxBit_reg   <= 3'h0;
         rxShift_reg <= 8'h00;
      end else if (!rxEnable) begin
         rxState_reg <= rs485_dir_pkg::SER_IDLE;
      end else begin
         rxCnt_reg <= rxCnt_reg + 16'h0001;
         case (rxState_reg)
            rs485_dir_pkg::SER_IDLE: begin
               rxCnt_reg <= 16'h0000;
               if (!lnk.devRxLine) rxState_reg <= rs485_dir_pkg::SER_START;
            end
            rs485_dir_pkg::SER_START: if (rxCnt_reg == (baud_reg >> 1)) begin
               rxCnt_reg   <= 16'h0000;
               rxBit_reg   <= 3'h0;
               rxState_reg <= lnk.devRxLine ? rs485_dir_pkg::SER_IDLE : rs485_dir_pkg::SER_DATA;
            end
            rs485_dir_pkg::SER_DATA: if (bitEnd(rxCnt_reg, baud_reg)) begin
               rxCnt_reg   <= 16'h0000;
               rxShift_reg <= {lnk.devRxLine, rxShift_reg[7:1]};
               rxBit_reg   <= rxBit_reg + 3'h1;
               if (rxBit_reg == 3'h7) rxState_reg <= rs485_dir_pkg::SER_STOP;
            end
            rs485_dir_pkg::SER_STOP: if (bitEnd(rxCnt_reg, baud_reg))
               rxState_reg <= rs485_dir_pkg::SER_IDLE;
            default: rxState_reg <= rs485_dir_pkg::SER_IDLE;
         endcase
      end
   end

   // own echoes are never handed to software
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxData_reg  <= 8'h00;
         rxValid_reg <= 1'b0;
      end else if (rxDone && !ownEcho) begin
         rxData_reg  <= rxShift_reg;
         rxValid_reg <= 1'b1;
      end else if (rdAcc && paddr == `RDC_OFF_RXDATA) begin
         rxValid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // acknowledge watchdog
   // ----------------------------------------
   // reply expected after each command
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmdOpen_reg <= 1'b0;
         ackWait_reg <= 1'b0;
         ackCnt_reg  <= 32'h0000_0000;
      end else begin
         if (txState_reg == rs485_dir_pkg::SER_START && addrPend_reg == 1'b0
             && txSent_reg == addr_reg)
            cmdOpen_reg <= ctrl_reg[`RDC_CTRL_ACK];
         if (cmdOpen_reg && !txActive && !txHoldValid_reg) begin
            cmdOpen_reg <= 1'b0;
            ackWait_reg <= 1'b1;
            ackCnt_reg  <= 32'h0000_0000;
         end else if (ackWait_reg) begin
            ackCnt_reg <= ackCnt_reg + 32'h0000_0001;
            if ((rxDone && !ownEcho) || ackCnt_reg == ACK_CYCLES - 1) ackWait_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // interrupts: set wins over clear
   // ----------------------------------------
   always_comb begin
      irqSet = 5'h00;
      irqSet[`RDC_IRQ_TXDONE]  = txEnd && !(txMayStart && txHoldValid_reg);
      irqSet[`RDC_IRQ_RXRDY]   = rxDone && !ownEcho;
      irqSet[`RDC_IRQ_OVERRUN] = rxDone && !ownEcho && rxValid_reg
                                 && !(rdAcc && paddr == `RDC_OFF_RXDATA);
      irqSet[`RDC_IRQ_CONTEND] = rxDone && ownEcho && ctrl_reg[`RDC_CTRL_LOOP]
                                 && rxShift_reg != txSent_reg;
      irqSet[`RDC_IRQ_NOACK]   = ackWait_reg && ackCnt_reg == ACK_CYCLES - 1
                                 && !(rxDone && !ownEcho);
      irqStat_next = irqStat_reg;
      if (wrAcc && paddr == `RDC_OFF_IRQCLR) irqStat_next = irqStat_reg & ~pwdata[4:0];
      irqStat_next = irqStat_next | irqSet;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) irqStat_reg <= 5'h00;
      else irqStat_reg <= irqStat_next;
   end

   assign irq = |(irqStat_reg & irqEn_reg);
endmodule // rs485_dir_ctrl
`default_nettype wire

// ===== verif/rs485_link_checker.sv
// concurrent checks on the shared pair between controller and node
`timescale 1ns/100ps
`default_nettype none
module rs485_link_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic devTxd,
   input wire logic devDe,
   input wire logic devRe,
   input wire logic fourWire,
   input wire logic nodeTxd,
   input wire logic nodeDe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // saturating count of cycles with no driver on the pair
   logic [3:0] quietCnt;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) quietCnt <= 4'hF;
      else if (devDe || nodeDe) quietCnt <= 4'h0;
      else if (quietCnt != 4'hF) quietCnt <= quietCnt + 4'h1;
   end
   sequence devRelease; devDe ##1 !devDe; endsequence
   sequence nodeRelease; nodeDe ##1 !nodeDe; endsequence
   a_one_driver: assert property (!fourWire |-> !(devDe && nodeDe))
      else $error("both drivers on");
   a_four_wire_on: assert property (fourWire |-> devDe && devRe)
      else $error("four-wire master not fully enabled");
   a_stop_before_off: assert property (devRelease |-> $past(devTxd))
      else $error("driver dropped inside a frame");
   a_start_driven: assert property ($fell(devTxd) |-> devDe)
      else $error("start bit without driver");
   a_echo_only_tx: assert property (!devRe |-> devDe && !fourWire)
      else $error("receiver off while not sending");
   a_idle_mark: assert property (!devDe |-> devTxd)
      else $error("idle driver data not mark");
   a_node_stop_off: assert property (nodeRelease |-> $past(nodeTxd))
      else $error("node dropped inside a frame");
   a_turn_gap: assert property ($rose(nodeDe) |-> quietCnt == 4'hF)
      else $error("node reply too close to master release");
endmodule // rs485_link_checker
`default_nettype wire

// ===== verif/tb_rs485_direction_control.sv
// self-checking bench: controller and node joined over the shared pair
`include "rs485_dir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin totalChecks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %s", $time, m); end end
module tb_rs485_direction_control;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, hsRts, hsDtr;
   logic        cmdStrobe, err;
   logic [7:0]  paddr, cmdData;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares, totalChecks, cycles, strobes, s;
   rs485_link_if lnk ();
   rs485_dir_ctrl #(.ACK_CYCLES(5000)) rs485_dir_ctrl_i (.clk_sys(clk_sys), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .hsRts(hsRts),
      .hsDtr(hsDtr), .lnk(lnk));
   rs485_node #(.BAUD_DIV(16'h0010), .TURN_CYCLES(200)) rs485_node_i (.clk_sys(clk_sys),
      .rst(rst), .myAddr(8'h21), .replyData(8'hA5), .cmdData(cmdData),
      .cmdStrobe(cmdStrobe), .replyBusy(), .lnk(lnk));
   rs485_link_checker rs485_link_checker_i (.clk_sys(clk_sys), .rst(rst),
      .devTxd(lnk.devTxd), .devDe(lnk.devDe), .devRe(lnk.devRe), .fourWire(lnk.fourWire),
      .nodeTxd(lnk.nodeTxd), .nodeDe(lnk.nodeDe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ---------------- timeout and strobe count ----------------
   always @(posedge clk_sys) begin
      cycles++;
      if (cmdStrobe === 1'b1) strobes++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wait_irq();
      while (irq !== 1'b1) @(posedge clk_sys);
   endtask
   task automatic reset_values();
      `CHK(hsDtr, 1'b1, "spare handshake low")
      `CHK(hsRts, 1'b1, "rts low in auto mode")
      `CHK(lnk.devDe, 1'b0, "driver on after reset")
      apb(1'b0, `RDC_OFF_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0001, "ctrl reset")
      apb(1'b0, `RDC_OFF_BAUD, 32'h0);
      `CHK(rd, 32'h0000_0364, "baud reset")
      apb(1'b0, 8'h24, 32'h0);
      `CHK(err, 1'b1, "unmapped not refused")
   endtask
   task automatic command_exchange();
      apb(1'b1, `RDC_OFF_BAUD, 32'h10);
      apb(1'b1, `RDC_OFF_ADDR, 32'h21);
      apb(1'b1, `RDC_OFF_IRQEN, 32'h3);
      apb(1'b1, `RDC_OFF_CTRL, 32'h5);
      s = strobes;
      apb(1'b1, `RDC_OFF_TXDATA, 32'h155);
      while (strobes == s) @(posedge clk_sys);
      `CHK(cmdData, 8'h55, "command data")
      `CHK(lnk.devRe, 1'b0, "echo heard")
      wait_irq();
      `CHK(lnk.devDe, 1'b0, "driver held after frame")
      apb(1'b0, `RDC_OFF_IRQSTAT, 32'h0);
      `CHK(rd[0], 1'b1, "tx done missing")
      apb(1'b1, `RDC_OFF_IRQCLR, 32'h1);
      wait_irq();
      apb(1'b0, `RDC_OFF_RXDATA, 32'h0);
      `CHK(rd, 32'h0000_01A5, "reply data")
      apb(1'b1, `RDC_OFF_IRQEN, 32'h0);
      `CHK(irq, 1'b0, "irq not masked")
      apb(1'b1, `RDC_OFF_IRQEN, 32'h2);
      `CHK(irq, 1'b1, "rx ready lost")
      apb(1'b1, `RDC_OFF_IRQCLR, 32'h1F);
      `CHK(irq, 1'b0, "irq not cleared")
   endtask
   task automatic other_address();
      apb(1'b1, `RDC_OFF_ADDR, 32'h22);
      s = strobes;
      apb(1'b1, `RDC_OFF_TXDATA, 32'h133);
      // two chars, turnaround and a reply would all fit in 700 cycles
      repeat (700) @(posedge clk_sys);
      `CHK(strobes, s, "foreign command taken")
      apb(1'b0, `RDC_OFF_IRQSTAT, 32'h0);
      `CHK(rd[1], 1'b0, "unasked reply")
   endtask
   task automatic four_wire_then_rts();
      apb(1'b1, `RDC_OFF_CTRL, 32'h8);
      `CHK(lnk.devDe && lnk.devRe, 1'b1, "four-wire not enabled")
      apb(1'b1, `RDC_OFF_IRQEN, 32'h1);
      apb(1'b1, `RDC_OFF_CTRL, 32'h0);
      // tx done from the previous scenario is still set and would end the wait too early
      apb(1'b1, `RDC_OFF_IRQCLR, 32'h1F);
      `CHK(hsRts, 1'b0, "rts not following ctrl")
      apb(1'b1, `RDC_OFF_TXDATA, 32'h0AA);
      repeat (50) @(posedge clk_sys);
      `CHK(lnk.devTxd, 1'b1, "sent before rts")
      apb(1'b1, `RDC_OFF_CTRL, 32'h2);
      `CHK(lnk.devDe, 1'b1, "rts did not enable driver")
      wait_irq();
      apb(1'b1, `RDC_OFF_CTRL, 32'h0);
      `CHK(lnk.devDe, 1'b0, "driver kept after rts low")
   endtask
   task automatic ack_watch();
      apb(1'b1, `RDC_OFF_CTRL, 32'h31);
      apb(1'b1, `RDC_OFF_ADDR, 32'h21);
      apb(1'b1, `RDC_OFF_IRQCLR, 32'h1F);
      apb(1'b1, `RDC_OFF_IRQEN, 32'h2);
      apb(1'b1, `RDC_OFF_TXDATA, 32'h155);
      wait_irq();
      apb(1'b0, `RDC_OFF_STATUS, 32'h0);
      `CHK(rd[4], 1'b0, "ack wait not cleared by reply")
      apb(1'b0, `RDC_OFF_IRQSTAT, 32'h0);
      `CHK(rd[4:2], 3'b000, "false contention or no-ack")
      apb(1'b1, `RDC_OFF_ADDR, 32'h22);
      apb(1'b1, `RDC_OFF_IRQEN, 32'h10);
      apb(1'b1, `RDC_OFF_TXDATA, 32'h155);
      wait_irq();
      apb(1'b0, `RDC_OFF_IRQSTAT, 32'h0);
      `CHK(rd[4], 1'b1, "no-ack not raised")
   endtask
   task automatic end_sim();
      if (miscompares == 0 && totalChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rst = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      reset_values();
      command_exchange();
      other_address();
      four_wire_then_rts();
      ack_watch();
      end_sim();
   end
endmodule // tb_rs485_direction_control
`default_nettype wire
